//--- mdrr_pkg.sv
// Package for the monitor data request responder
package mdrr_pkg;
    localparam logic [15:0] MDRR_VEC_LO_ADDR   = 16'h0008;
    localparam logic [15:0] MDRR_VEC_HI_ADDR   = 16'h000b;
    localparam logic [15:0] MDRR_REQ_ADDR_EN   = 16'd395;
    localparam logic [15:0] MDRR_ACK_EN        = 16'd398;
    localparam logic [15:0] MDRR_MON_LO_EN     = 16'd399;
    localparam logic [15:0] MDRR_MON_HI_EN     = 16'd400;
    localparam logic [15:0] MDRR_EOI_ADDR      = 16'hff22;
    localparam logic [15:0] MDRR_EOI_VALUE     = 16'h0002;
    localparam logic [15:0] MDRR_ADDR_MIN      = 16'd16;
    localparam logic [15:0] MDRR_ADDR_MAX      = 16'd47;
    localparam logic [15:0] MDRR_ARRAY_BASE    = 16'h2000;
    localparam logic [15:0] MDRR_FAULT_SET     = 16'h0040;
    localparam logic [15:0] MDRR_FAULT_CLR     = 16'hffbf;
    localparam int          MDRR_FAULT_BIT     = 6;
    localparam int          MDRR_PRIORITY      = 1;
    localparam int          MDRR_ENTRIES       = 32;
    localparam logic [15:0] MDRR_FAULT_RST     = 16'h0000;

    typedef enum logic [3:0] {
        MDRR_IDLE   = 4'b0000,
        MDRR_VEC    = 4'b0001,
        MDRR_RDADR  = 4'b0011,
        MDRR_CHECK  = 4'b0010,
        MDRR_FETCH  = 4'b0110,
        MDRR_WAITM  = 4'b0111,
        MDRR_OUTLO  = 4'b0101,
        MDRR_OUTHI  = 4'b0100,
        MDRR_ACK    = 4'b1100,
        MDRR_EOI    = 4'b1101
    } mdrr_state_t;

    typedef struct packed {
        logic        strobe;
        logic        is_write;
        logic [15:0] addr;
        logic [7:0]  data;
    } mdrr_io_t;
endpackage

//--- mdrr_mem.sv
// Monitor data array with registered read port
`timescale 1ns/1ps
module mdrr_mem
    import mdrr_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  wr_idx_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic [4:0]  rd_idx_i,
    output logic      [15:0] rd_data_o
);
    logic [15:0] words [MDRR_ENTRIES];

    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            words[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        rd_data_o <= words[rd_idx_i];
    end
endmodule

//--- mdrr_top.sv
// Monitor data request responder top
//
// Functional notes
// - Data request is unmaskable, top priority
// - Fetch handler vector from 0008 to 000B
// - Read request address byte at enable 395
// - Zero-extend address byte before range check
// - Accept only addresses 16 through 47
// - Bad address sets fault bit 6, no output
// - Index is address minus 16, doubled
// - Monitor word read from array at 2000H
// - Write word low at 399, high next
// - Write any byte to 398 for acknowledge
// - Success clears fault bit 6 via 0FFBFH
// - Write 2 to end-of-interrupt register
// - Save, clear, restore range fault flag
// - Finish output before interface timeout
// - End-of-interrupt register at FF22H
`timescale 1ns/1ps
module mdrr_top
    import mdrr_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        data_req_i,
    input  wire logic [7:0]  io_rdata_i,
    input  wire logic        range_fault_set_i,
    input  wire logic        mon_wr_en_i,
    input  wire logic [4:0]  mon_wr_idx_i,
    input  wire logic [15:0] mon_wr_data_i,
    output mdrr_io_t         io_o,
    output logic             vec_fetch_o,
    output logic [15:0]      vec_addr_o,
    output logic [15:0]      fault_word_o,
    output logic             range_fault_flag_o,
    output logic             busy_o
);
    mdrr_state_t state;
    logic        pending;
    logic [15:0] req_addr;
    logic [15:0] mon_word;
    logic [15:0] mem_word;
    logic [15:0] byte_off;
    logic [4:0]  rd_idx;
    logic        saved_flag;
    logic        addr_ok;

    // Zero extension keeps the neighbouring argument byte out of the check
    assign addr_ok  = (req_addr >= MDRR_ADDR_MIN) && (req_addr <= MDRR_ADDR_MAX);
    assign byte_off = (req_addr - MDRR_ADDR_MIN) << 1;
    assign rd_idx   = byte_off[5:1];
    assign busy_o   = (state != MDRR_IDLE);

    // Slot i holds monitor address 16+i, two bytes per slot from 2000H
    mdrr_mem u_mem (
        .clock_i   (clock_i),
        .wr_en_i   (mon_wr_en_i),
        .wr_idx_i  (mon_wr_idx_i),
        .wr_data_i (mon_wr_data_i),
        .rd_idx_i  (rd_idx),
        .rd_data_o (mem_word)
    );

    // No mask input exists, so a request is always latched; busy holds off the next
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pending <= 1'b0;
        end else if (data_req_i) begin
            pending <= 1'b1;
        end else if (state == MDRR_IDLE && pending) begin
            pending <= 1'b0;
        end
    end

    // A bad address skips the output states and goes straight to exit
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= MDRR_IDLE;
        end else begin
            unique case (state)
                MDRR_IDLE:  if (pending) state <= MDRR_VEC;
                MDRR_VEC:   if (vec_addr_o == MDRR_VEC_HI_ADDR) state <= MDRR_RDADR;
                MDRR_RDADR: state <= MDRR_CHECK;
                MDRR_CHECK: state <= addr_ok ? MDRR_FETCH : MDRR_EOI;
                MDRR_FETCH: state <= MDRR_WAITM;
                MDRR_WAITM: state <= MDRR_OUTLO;
                MDRR_OUTLO: state <= MDRR_OUTHI;
                MDRR_OUTHI: state <= MDRR_ACK;
                MDRR_ACK:   state <= MDRR_EOI;
                MDRR_EOI:   state <= MDRR_IDLE;
                default:    state <= MDRR_IDLE;
            endcase
        end
    end

    // Vector fetch walks the four vector bytes
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            vec_addr_o <= MDRR_VEC_LO_ADDR;
        end else if (state == MDRR_IDLE && pending) begin
            vec_addr_o <= MDRR_VEC_LO_ADDR;
        end else if (state == MDRR_VEC && vec_addr_o != MDRR_VEC_HI_ADDR) begin
            vec_addr_o <= vec_addr_o + 16'h0001;
        end
    end

    // One pulse per vector byte, four in all
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            vec_fetch_o <= 1'b0;
        end else begin
            vec_fetch_o <= (state == MDRR_IDLE && pending)
                        || (state == MDRR_VEC && vec_addr_o != MDRR_VEC_HI_ADDR);
        end
    end

    // Address byte is sampled the cycle after its read strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            req_addr <= 16'h0000;
        end else if (state == MDRR_RDADR) begin
            req_addr <= {8'h00, io_rdata_i};
        end
    end

    // Registered copy holds the word while its bytes go out
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mon_word <= 16'h0000;
        end else if (state == MDRR_WAITM) begin
            mon_word <= mem_word;
        end
    end

    // Bus strobes, at most one per cycle, chosen by state
    // Address read repeats in each vector cycle; the byte is taken after the last
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            io_o <= '0;
        end else begin
            io_o <= '0;
            unique case (state)
                MDRR_VEC: begin
                    io_o.strobe   <= 1'b1;
                    io_o.is_write <= 1'b0;
                    io_o.addr     <= MDRR_REQ_ADDR_EN;
                end
                MDRR_WAITM: begin
                    io_o.strobe   <= 1'b1;
                    io_o.is_write <= 1'b1;
                    io_o.addr     <= MDRR_MON_LO_EN;
                    io_o.data     <= mem_word[7:0];
                end
                MDRR_OUTLO: begin
                    io_o.strobe   <= 1'b1;
                    io_o.is_write <= 1'b1;
                    io_o.addr     <= MDRR_MON_HI_EN;
                    io_o.data     <= mon_word[15:8];
                end
                MDRR_OUTHI: begin
                    io_o.strobe   <= 1'b1;
                    io_o.is_write <= 1'b1;
                    io_o.addr     <= MDRR_ACK_EN;
                    io_o.data     <= mon_word[7:0];
                end
                MDRR_ACK: begin
                    io_o.strobe   <= 1'b1;
                    io_o.is_write <= 1'b1;
                    io_o.addr     <= MDRR_EOI_ADDR;
                    io_o.data     <= MDRR_EOI_VALUE[7:0];
                end
                MDRR_CHECK: begin
                    if (!addr_ok) begin
                        io_o.strobe   <= 1'b1;
                        io_o.is_write <= 1'b1;
                        io_o.addr     <= MDRR_EOI_ADDR;
                        io_o.data     <= MDRR_EOI_VALUE[7:0];
                    end
                end
                default: io_o <= '0;
            endcase
        end
    end

    // Only bit 6 is touched; other bits stay as other code left them
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fault_word_o <= MDRR_FAULT_RST;
        end else if (state == MDRR_CHECK && !addr_ok) begin
            fault_word_o <= fault_word_o | MDRR_FAULT_SET;
        end else if (state == MDRR_ACK) begin
            fault_word_o <= fault_word_o & MDRR_FAULT_CLR;
        end
    end

    // Saved copy also takes a set that lands while the handler runs
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            saved_flag <= 1'b0;
        end else if (state == MDRR_IDLE && pending) begin
            saved_flag <= range_fault_flag_o | range_fault_set_i;
        end else if (state != MDRR_IDLE && range_fault_set_i) begin
            saved_flag <= 1'b1;
        end
    end

    // Cleared for the handler's own check, restored on exit; a set wins over the exit restore, the entry clear wins over a set
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            range_fault_flag_o <= 1'b0;
        end else if (state == MDRR_IDLE && pending) begin
            range_fault_flag_o <= 1'b0;
        end else if (state == MDRR_EOI) begin
            range_fault_flag_o <= saved_flag | range_fault_set_i;
        end else if (state == MDRR_CHECK && !addr_ok) begin
            range_fault_flag_o <= 1'b1;
        end else if (range_fault_set_i && state == MDRR_IDLE) begin
            range_fault_flag_o <= 1'b1;
        end
    end
endmodule

//--- mdrr_assertions.sv
// Port checker for the responder
`timescale 1ns/1ps
module mdrr_checker
    import mdrr_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire mdrr_io_t    io_o,
    input wire logic        vec_fetch_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic [15:0] fault_word_o,
    input wire logic        busy_o
);
    logic        st;
    logic [15:0] ad;
    assign st = io_o.strobe;
    assign ad = io_o.addr;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    property p_vec; vec_fetch_o |-> vec_addr_o inside {[16'h0008:16'h000b]}; endproperty
    a_vec: assert property (p_vec) else $error("vector address");
    property p_rd; st && ad == 16'd395 |-> !io_o.is_write; endproperty
    a_rd: assert property (p_rd) else $error("address read");
    property p_seq;
        st && ad == 16'd399 |=> st && ad == 16'd400 ##1 st && ad == 16'd398; endproperty
    a_seq: assert property (p_seq) else $error("output order");
    property p_clr; st && ad == 16'd398 |-> ##[0:1] !fault_word_o[6]; endproperty
    a_clr: assert property (p_clr) else $error("fault not cleared");
    property p_keep;
        $changed(fault_word_o) |-> (fault_word_o ^ $past(fault_word_o)) == 16'h0040; endproperty
    a_keep: assert property (p_keep) else $error("other fault bits");
    property p_bad; $rose(fault_word_o[6]) |-> !(st && ad == 16'd399) [*5]; endproperty
    a_bad: assert property (p_bad) else $error("output after bad address");
    property p_eoi; st && ad == 16'hff22 |-> io_o.is_write && io_o.data == 8'h02; endproperty
    a_eoi: assert property (p_eoi) else $error("end of interrupt");
    property p_bnd; $rose(busy_o) |-> ##[1:40] st && ad == 16'hff22; endproperty
    a_bnd: assert property (p_bnd) else $error("handling too long");
endmodule

//--- mdrr_iface_model.sv
// Interface module model on the responder bus
`timescale 1ns/1ps
module mdrr_iface_model
    import mdrr_pkg::*;
(
    input  wire logic        clock_i,
    input  wire mdrr_io_t    io_i,
    input  wire logic [7:0]  req_byte_i,
    output logic      [7:0]  io_rdata_o,
    output logic      [15:0] mon_word_o,
    output int               n_ack_o,
    output int               n_eoi_o
);
    logic held = 1'b0;
    initial begin
        mon_word_o = 16'h0000;
        n_ack_o = 0;
        n_eoi_o = 0;
    end
    // Inverted when released so a stale byte never looks valid
    assign io_rdata_o = held ? req_byte_i : ~req_byte_i;
    always @(posedge clock_i) begin
        if (io_i.strobe && !io_i.is_write && io_i.addr == 16'd395) begin
            held <= 1'b1;
        end else if (io_i.strobe) begin
            held <= 1'b0;
            case (io_i.addr)
                16'd399: mon_word_o[7:0] <= io_i.data;
                16'd400: mon_word_o[15:8] <= io_i.data;
                16'd398: n_ack_o <= n_ack_o + 1;
                16'hff22: n_eoi_o <= n_eoi_o + 1;
                default: ;
            endcase
        end
    end
endmodule

//--- tb_monitor_data_request_responder.sv
// Testbench for the monitor data request responder
`timescale 1ns/1ps
module tb_monitor_data_request_responder
    import mdrr_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        data_req_i = 1'b0;
    logic        range_fault_set_i = 1'b0;
    logic        mon_wr_en_i = 1'b0;
    logic [4:0]  mon_wr_idx_i = 5'h00;
    logic [15:0] mon_wr_data_i = 16'h0000;
    logic [7:0]  req_byte = 8'h00;
    logic [7:0]  io_rdata_i;
    mdrr_io_t    io_o;
    logic        vec_fetch_o, range_fault_flag_o, busy_o;
    logic [15:0] vec_addr_o, fault_word_o, mon_word;
    int          n_ack, n_eoi, bad_count = 0, comparisons = 0;
    always #10 clock_i = ~clock_i;
    mdrr_top DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .data_req_i(data_req_i),
        .io_rdata_i(io_rdata_i), .range_fault_set_i(range_fault_set_i),
        .mon_wr_en_i(mon_wr_en_i), .mon_wr_idx_i(mon_wr_idx_i), .mon_wr_data_i(mon_wr_data_i),
        .io_o(io_o), .vec_fetch_o(vec_fetch_o), .vec_addr_o(vec_addr_o),
        .fault_word_o(fault_word_o), .range_fault_flag_o(range_fault_flag_o), .busy_o(busy_o));
    mdrr_iface_model PM (.clock_i(clock_i), .io_i(io_o), .req_byte_i(req_byte),
        .io_rdata_o(io_rdata_i), .mon_word_o(mon_word), .n_ack_o(n_ack), .n_eoi_o(n_eoi));
    task automatic tick;
        @(posedge clock_i) #1;
    endtask
    function automatic logic [15:0] wd(logic [7:0] i);
        return 16'h5a00 ^ {i, i};
    endfunction
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic serve(logic [7:0] b, int reqs);
        int n;
        int t;
        t = n_eoi + reqs;
        req_byte = b;
        for (n = 0; n < reqs; n++) begin
            data_req_i = 1'b1;
            tick;
            data_req_i = 1'b0;
            repeat (2) tick;
        end
        for (n = 0; n < 200 && (n_eoi != t || busy_o !== 1'b0); n++) tick;
        tick;
        chk("served", 16'h0000, 16'(n / 200));
    endtask
    task automatic t_bounds;
        logic [7:0]  tab [7] = '{8'h0f, 8'h10, 8'h2f, 8'h30, 8'h00, 8'hff, 8'h1f};
        logic [15:0] w;
        int          a, e, v;
        foreach (tab[k]) begin
            a = n_ack;
            e = n_eoi;
            w = mon_word;
            v = int'({8'h00, tab[k]} inside {[16'd16:16'd47]});
            serve(tab[k], 1);
            chk("eoi", 16'(e + 1), 16'(n_eoi));
            chk("ack", 16'(a + v), 16'(n_ack));
            chk("word", v ? wd(tab[k] - 8'd16) : w, mon_word);
            chk("fault", v ? 16'h0000 : 16'h0040, fault_word_o);
            chk("flag", 16'h0000, {15'h0000, range_fault_flag_o});
            chk("vector", 16'h000b, vec_addr_o);
        end
    endtask
    task automatic t_flag;
        req_byte = 8'h14;
        data_req_i = 1'b1;
        tick;
        data_req_i = 1'b0;
        repeat (3) tick;
        range_fault_set_i = 1'b1;
        tick;
        range_fault_set_i = 1'b0;
        repeat (20) tick;
        chk("held", 16'h0001, {15'h0000, range_fault_flag_o});
        range_fault_set_i = 1'b1;
        tick;
        range_fault_set_i = 1'b0;
        serve(8'h14, 1);
        chk("kept", 16'h0001, {15'h0000, range_fault_flag_o});
        chk("word", wd(8'h04), mon_word);
    endtask
    task automatic t_b2b;
        int a;
        a = n_ack;
        serve(8'h2e, 2);
        chk("acks", 16'(a + 2), 16'(n_ack));
        chk("word", wd(8'h1e), mon_word);
    endtask
    task automatic stop_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        for (int i = 0; i < MDRR_ENTRIES; i++) begin
            mon_wr_en_i = 1'b1;
            mon_wr_idx_i = i[4:0];
            mon_wr_data_i = wd(8'(i));
            tick;
        end
        mon_wr_en_i = 1'b0;
        t_bounds;
        t_flag;
        t_b2b;
        stop_test;
    end
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end
endmodule
bind mdrr_top mdrr_checker CHK (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .io_o(io_o),
    .vec_fetch_o(vec_fetch_o), .vec_addr_o(vec_addr_o), .fault_word_o(fault_word_o),
    .busy_o(busy_o));
